// ### src/buck_seq_top.sv
// Configuration registers and start-up sequencing for a three-channel buck controller.
// How it works
// - Output voltage registers 00h-02h, 6-bit code.
// - Bit 7 selects external feedback divider.
// - Frequency 300kHz to 2.2MHz, 100kHz steps.
// - Frequency code in low five bits, 09h.
// - Per-channel peak limit 1A-4A, 0.5A steps.
// - Current-limit codes at 06h, 07h, 08h.
// - Soft-start codes at 03h-05h, low bits.
// - Soft-start 0.5ms-4ms at 1MHz.
// - Soft-start 1ms-8ms at 500kHz.
// - Start needs enable high and select bit.
// - Delay codes in bits 6:4, 03h-05h.
// - Delay 0ms-35ms at 1MHz.
// - Delay 0ms-70ms at 500kHz.
// - Sync ignored until power good asserted.
// - Lock sync to 2.31MHz once all timers have expired.
// - Skip mode enables zero-current and skip together.
// - Skip comparator low current omits pulses.
// - Phase select in bits 6:5 of 09h.
// - Power good: low below 85%, high after timer.
`timescale 1ns/10ps
`include "buck_seq_params.svh"
module buck_seq_top #(
    parameter int PG_TIMER = `PG_TIMER_SW,
    parameter int DLY_STEP = `DLY_STEP_SW,
    parameter int SS_STEP  = `SS_STEP_SW
) (
    // Clock, reset and clock enable
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    // Register access port from the serial interface
    input  wire logic                    reg_wr,
    input  wire logic [3:0]              reg_addr,
    input  wire buck_seq_pkg::reg_byte_t reg_wdata,
    output      buck_seq_pkg::reg_byte_t reg_rdata,
    // Control pins
    input  wire logic                    enable_pin,
    input  wire logic [2:0]              channel_select,
    input  wire logic                    sync_pin,
    input  wire logic                    pulse_skipping_mode,
    input  wire logic [2:0]              skip_low_current,
    input  wire logic [2:0]              above_90pct,
    input  wire logic [2:0]              below_85pct,
    // Per-channel and shared outputs to the analog loop
    output      logic [17:0]             vout_code,
    output      logic [2:0]              external_feedback_select,
    output      logic [8:0]              current_limit_code,
    output      logic [2:0]              channel_ramping,
    output      logic [2:0]              channel_running,
    output      logic [2:0]              zero_current_detector,
    output      logic [2:0]              skip_comparator_en,
    output      logic [2:0]              pulse_enable,
    output      logic [1:0]              phase_select,
    output      logic [4:0]              fsw_code,
    output      logic                    sw_clk,
    output      logic                    sync_locked,
    output      logic                    power_good_output
);
    import buck_seq_pkg::*;
    localparam int FSW_MAX_CODE = 19;
    reg_byte_t regs_q [10];
    // Pin synchronisers: first stage read only by the second.
    logic [8:0] pin_s1_q;
    logic [8:0] pin_s2_q;
    logic       en_s, sync_s, psm_s;
    logic [2:0] sel_s, skip_s;
    logic       sync_prev_q;
    logic       sync_rise;
    // Internal oscillator.
    logic [15:0] osc_cnt_q;
    logic [15:0] osc_half;
    logic [4:0]  fsw_eff;
    logic        osc_tick;
    logic        sw_clk_q;
    logic        sw_tick;
    logic        sync_mode_q;
    // Power good timer.
    logic [20:0] pg_cnt_q;
    logic        pg_q;
    logic        all_above;
    logic        any_below;
    logic        all_seq_done;
    logic [2:0]  ch_on;
    logic [2:0]  ch_ramp;
    assign all_above = &(above_90pct | ~sel_s);
    assign any_below = |(below_85pct & sel_s);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
        end else if (clk_en) begin
            pin_s1_q <= {enable_pin, channel_select, sync_pin, pulse_skipping_mode, skip_low_current};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign {en_s, sel_s, sync_s, psm_s, skip_s} = pin_s2_q;
    // Register file: writes to 00h-09h land in run-time registers; writes to other addresses are dropped.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                regs_q[i]   <= `RST_VOUT;
                regs_q[i+3] <= `RST_SS;
                regs_q[i+6] <= `RST_ILIM;
            end
            regs_q[9] <= `RST_FSW;
        end else if (clk_en && reg_wr && reg_addr <= `OFS_FSW) begin
            regs_q[reg_addr] <= reg_wdata;
        end
    end
    logic addr_ok;
    assign addr_ok = (reg_addr <= `OFS_FSW);
    assign reg_rdata = addr_ok ? regs_q[reg_addr] : 8'h00;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cfg
            assign vout_code[6*g +: 6] = regs_q[g][`VCODE_MSB:0];
            assign external_feedback_select[g] = regs_q[g][`EXT_FB_BIT];
            assign current_limit_code[3*g +: 3] = regs_q[g+6][`ILIM_MSB:0];
        end
    endgenerate
    assign fsw_code     = regs_q[9][`FSW_MSB:0];
    assign phase_select = regs_q[9][`PHASE_MSB:`PHASE_LSB];
    // Codes past 2.2MHz are clamped so the oscillator stays in range.
    assign fsw_eff  = (fsw_code > 5'(FSW_MAX_CODE)) ? 5'(FSW_MAX_CODE) : fsw_code;
    // Half period in system clocks: f = 300kHz + code*100kHz.
    assign osc_half = 16'(`CLK_SYS_KHZ / (2 * (`OSC_BASE_KHZ + `OSC_STEP_KHZ * int'(fsw_eff))));
    assign osc_tick = (osc_cnt_q + 16'h0001 >= osc_half);
    assign sync_rise = sync_s & ~sync_prev_q;
    // After lock the sync edge becomes the switching event; the channel and power good timers have expired by then.
    assign sw_tick  = sync_mode_q ? sync_rise : (osc_tick & sw_clk_q);
    assign sw_clk   = sync_mode_q ? sync_s : sw_clk_q;
    assign sync_locked = sync_mode_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            osc_cnt_q   <= 16'h0000;
            sw_clk_q    <= 1'b0;
            sync_prev_q <= 1'b0;
            sync_mode_q <= 1'b0;
        end else if (clk_en) begin
            sync_prev_q <= sync_s;
            if (osc_tick) begin
                osc_cnt_q <= 16'h0000;
                sw_clk_q  <= ~sw_clk_q;
            end else begin
                osc_cnt_q <= osc_cnt_q + 16'h0001;
            end
            // Sync is only honoured once power good is up, and dropped with it.
            if (!pg_q) begin
                sync_mode_q <= 1'b0;
            end else if (sync_rise) begin
                sync_mode_q <= 1'b1;
            end
        end
    end
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            buck_ch_if chi ();
            assign chi.start    = en_s & sel_s[g];
            assign chi.sw_tick  = sw_tick;
            assign chi.ss_code  = regs_q[g+3][`SS_CODE_MSB:0];
            assign chi.dly_code = regs_q[g+3][`DLY_CODE_MSB:`DLY_CODE_LSB];
            assign ch_on[g]     = chi.ramp_done;
            assign ch_ramp[g]   = (chi.state == CH_RAMP);
            buck_ch_seq #(
                .DLY_STEP (DLY_STEP),
                .SS_STEP  (SS_STEP)
            ) u_seq (
                .clk_sys (clk_sys),
                .reset   (reset),
                .clk_en  (clk_en),
                .ch      (chi.seq)
            );
        end
    endgenerate
    assign channel_running = ch_on;
    assign channel_ramping = ch_ramp;
    assign all_seq_done    = en_s && (sel_s != 3'b000) && ((ch_on & sel_s) == sel_s);
    // Both light-load functions share one enable.
    assign zero_current_detector = (psm_s ? 3'b111 : 3'b000) & ch_on;
    assign skip_comparator_en    = (psm_s ? 3'b111 : 3'b000) & ch_on;
    assign pulse_enable = (ch_on | ch_ramp) & ~(skip_comparator_en & skip_s);
    // The reset timer runs in switching cycles at the internal rate; sync can only lock after it has expired.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pg_cnt_q <= 21'h000000;
            pg_q     <= 1'b0;
        end else if (clk_en) begin
            if (any_below || !all_seq_done) begin
                pg_cnt_q <= 21'h000000;
                pg_q     <= 1'b0;
            end else if (all_above && pg_cnt_q >= 21'(PG_TIMER)) begin
                pg_q <= 1'b1;
            end else if (all_above && sw_tick) begin
                pg_cnt_q <= pg_cnt_q + 21'h000001;
            end
        end
    end
    assign power_good_output = pg_q;
endmodule

// ### src/buck_seq_params.svh
// Register offsets, field positions, reset values and timing counts for the buck sequencer.
`ifndef BUCK_SEQ_PARAMS_SVH
`define BUCK_SEQ_PARAMS_SVH
`define OFS_VOUT1        4'h0
`define OFS_VOUT2        4'h1
`define OFS_VOUT3        4'h2
`define OFS_SS1          4'h3
`define OFS_SS2          4'h4
`define OFS_SS3          4'h5
`define OFS_ILIM1        4'h6
`define OFS_ILIM2        4'h7
`define OFS_ILIM3        4'h8
`define OFS_FSW          4'h9
`define EXT_FB_BIT       7
`define VCODE_MSB        5
`define SS_CODE_MSB      2
`define DLY_CODE_MSB     6
`define DLY_CODE_LSB     4
`define ILIM_MSB         2
`define FSW_MSB          4
`define PHASE_MSB        6
`define PHASE_LSB        5
`define RST_VOUT         8'h00
`define RST_SS           8'h00
`define RST_ILIM         8'h00
`define RST_FSW          8'h07
`define DLY_STEP_SW      5000
`define SS_STEP_SW       500
`define PG_TIMER_SW      1000000
`define OSC_BASE_KHZ     300
`define OSC_STEP_KHZ     100
`define CLK_SYS_KHZ      25000
`endif

// ### src/buck_seq_pkg.sv
// Types shared by the buck sequencer modules.
package buck_seq_pkg;
    typedef enum logic [1:0] {
        CH_OFF,
        CH_DELAY,
        CH_RAMP,
        CH_ON
    } ch_state_e;
    typedef logic [7:0] reg_byte_t;
endpackage

// ### src/buck_ch_if.sv
// Signals between the sequencer top and one channel start-up sequencer.
`timescale 1ns/10ps
interface buck_ch_if;
    import buck_seq_pkg::*;
    logic      start;
    logic      sw_tick;
    logic [2:0] dly_code;
    logic [2:0] ss_code;
    ch_state_e state;
    logic      ramp_done;
    modport seq (input start, input sw_tick, input dly_code, input ss_code, output state, output ramp_done);
    modport top (output start, output sw_tick, output dly_code, output ss_code, input state, input ramp_done);
endinterface

// ### src/buck_ch_seq.sv
// One channel start-up sequencer: delay, then soft-start ramp, counted in switching cycles.
`timescale 1ns/10ps
`include "buck_seq_params.svh"
module buck_ch_seq #(
    parameter int DLY_STEP = `DLY_STEP_SW,
    parameter int SS_STEP  = `SS_STEP_SW
) (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset,
    input  wire logic   clk_en,
    // Channel link
    buck_ch_if.seq      ch
);
    import buck_seq_pkg::*;
    ch_state_e   state_q;
    logic [19:0] cnt_q;
    logic [19:0] dly_len;
    logic [19:0] ss_len;
    // Delay is code*step; soft-start is (code+1)*step.
    assign dly_len = 20'(ch.dly_code * DLY_STEP);
    assign ss_len  = 20'((ch.ss_code + 4'd1) * SS_STEP);
    assign ch.state     = state_q;
    assign ch.ramp_done = (state_q == CH_ON);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= CH_OFF;
            cnt_q   <= 20'h00000;
        end else if (clk_en) begin
            if (!ch.start) begin
                state_q <= CH_OFF;
                cnt_q   <= 20'h00000;
            end else begin
                case (state_q)
                    CH_OFF: begin
                        state_q <= CH_DELAY;
                        cnt_q   <= 20'h00000;
                    end
                    CH_DELAY: begin
                        if (cnt_q >= dly_len) begin
                            state_q <= CH_RAMP;
                            cnt_q   <= 20'h00000;
                        end else if (ch.sw_tick) begin
                            cnt_q <= cnt_q + 20'h00001;
                        end
                    end
                    CH_RAMP: begin
                        if (cnt_q >= ss_len) begin
                            state_q <= CH_ON;
                        end else if (ch.sw_tick) begin
                            cnt_q <= cnt_q + 20'h00001;
                        end
                    end
                    default: state_q <= CH_ON;
                endcase
            end
        end
    end
endmodule

// ### dv/buck_seq_top_assertions.sv
// Concurrent checks on the buck sequencer top ports.
`timescale 1ns/10ps
module buck_seq_top_assertions (
    // Inputs
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        reg_wr,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        enable_pin,
    input wire logic [2:0]  channel_select,
    input wire logic [2:0]  below_85pct,
    // Outputs
    input wire logic [17:0] vout_code,
    input wire logic [2:0]  external_feedback_select,
    input wire logic [2:0]  channel_ramping,
    input wire logic [2:0]  channel_running,
    input wire logic [2:0]  zero_current_detector,
    input wire logic [2:0]  skip_comparator_en,
    input wire logic [2:0]  pulse_enable,
    input wire logic [1:0]  phase_select,
    input wire logic [4:0]  fsw_code,
    input wire logic        sync_locked,
    input wire logic        power_good_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire wr_now = reg_wr && clk_en;
    fsw_load_a: assert property (wr_now && reg_addr == 4'h9 |=> fsw_code == $past(reg_wdata[4:0]))
        else $error("fsw code not loaded");
    phase_load_a: assert property (wr_now && reg_addr == 4'h9 |=> phase_select == $past(reg_wdata[6:5]))
        else $error("phase select not loaded");
    vout_load_a: assert property (wr_now && reg_addr == 4'h1 |=>
        vout_code[11:6] == $past(reg_wdata[5:0]) && external_feedback_select[1] == $past(reg_wdata[7]))
        else $error("voltage code not loaded");
    skip_pair_a: assert property (zero_current_detector == skip_comparator_en
        && (skip_comparator_en & ~channel_running) == 3'h0) else $error("skip functions not paired");
    pulse_gate_a: assert property ((pulse_enable & ~(channel_ramping | channel_running)) == 3'h0)
        else $error("pulse on idle channel");
    enable_gate_a: assert property ((!enable_pin && clk_en) [*5] |-> (channel_ramping | channel_running) == 3'h0)
        else $error("channel active without enable");
    pg_drop_a: assert property (((below_85pct & channel_select) != 3'h0 && clk_en) [*4] |=> !power_good_output)
        else $error("power good held while low");
    sync_lock_a: assert property ($rose(sync_locked) |-> $past(power_good_output))
        else $error("sync locked before power good");
endmodule
bind buck_seq_top buck_seq_top_assertions u_chk (.clk_sys, .reset, .clk_en, .reg_wr, .reg_addr, .reg_wdata,
    .enable_pin, .channel_select, .below_85pct, .vout_code, .external_feedback_select, .channel_ramping,
    .channel_running, .zero_current_detector, .skip_comparator_en, .pulse_enable, .phase_select, .fsw_code,
    .sync_locked, .power_good_output);

// ### dv/i2c_host_model.sv
// Serial host stand-in that drives the register port at the falling edge.
`timescale 1ns/10ps
module i2c_host_model #(
    parameter int BOOT = 5000
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Bench requests
    input  wire logic       req,
    input  wire logic [3:0] a,
    input  wire logic [7:0] d,
    output      logic       ready,
    // Register port
    output      logic       reg_wr,
    output      logic [3:0] reg_addr,
    output      logic [7:0] reg_wdata
);
    int boot_cnt;
    // Defaults load after power-on, so no access is made until the boot count expires.
    always @(negedge clk_sys) begin
        boot_cnt <= reset ? 0 : boot_cnt + 1;
        ready <= !reset && boot_cnt >= BOOT;
        reg_wr <= ready && req;
        reg_addr <= a;
        // Idle data is inverted so the device cannot profit from a stale byte.
        reg_wdata <= (ready && req) ? d : ~d;
    end
endmodule

// ### dv/test_buck_seq_top.sv
// Self-checking bench for the buck sequencer top.
`timescale 1ns/10ps
module test_buck_seq_top;
    import buck_seq_pkg::*;
    localparam int DLY = 5;
    localparam int SS  = 2;
    logic        clk_sys, reset, clk_en, req, ready, reg_wr, chk, sw_clk, sync_locked, power_good_output;
    logic        enable_pin, sync_pin, pulse_skipping_mode, sync_run;
    logic [3:0]  a, reg_addr;
    reg_byte_t   d, reg_wdata, reg_rdata, v, r [10], exp_q [$];
    logic [2:0]  channel_select, skip_low_current, above_90pct, below_85pct, s, external_feedback_select;
    logic [2:0]  channel_ramping, channel_running, zero_current_detector, skip_comparator_en, pulse_enable;
    logic [17:0] vout_code;
    logic [8:0]  current_limit_code;
    logic [1:0]  phase_select;
    logic [4:0]  fsw_code;
    int          bad_count, samples_checked, ticks, t1, n, sc, codes [3] = '{0, 19, 7};
    time         t0;
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    i2c_host_model HOST (.clk_sys, .reset, .req, .a, .d, .ready, .reg_wr, .reg_addr, .reg_wdata);
    buck_seq_top #(.PG_TIMER(10), .DLY_STEP(DLY), .SS_STEP(SS)) DUT (.clk_sys, .reset, .clk_en, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .enable_pin, .channel_select, .sync_pin, .pulse_skipping_mode,
        .skip_low_current, .above_90pct, .below_85pct, .vout_code, .external_feedback_select, .current_limit_code,
        .channel_ramping, .channel_running, .zero_current_detector, .skip_comparator_en, .pulse_enable,
        .phase_select, .fsw_code, .sw_clk, .sync_locked, .power_good_output);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input reg_byte_t val);
        @(posedge clk_sys);
        {a, d, req} <= {ad, val, 1'b1};
        @(posedge clk_sys);
        req <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input reg_byte_t val);
        @(posedge clk_sys);
        a <= ad;
        exp_q.push_back(val);
        chk <= 1'b1;
        @(posedge clk_sys);
        chk <= 1'b0;
    endtask
    task automatic results;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys) if (chk) check(32'(reg_rdata), 32'(exp_q.pop_front()));
    always @(posedge sw_clk) ticks++;
    // A 20-cycle sync period sits above the 1 MHz internal rate so it can take over.
    always @(negedge clk_sys) begin
        sc <= sc + 1;
        if (sync_run && sc % 10 == 0) sync_pin <= ~sync_pin;
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        results();
    end
    initial begin
        void'($urandom(23));
        {reset, clk_en, req, chk, a, d, enable_pin, sync_pin, sync_run, pulse_skipping_mode} = {3'h6, 1'b0, 12'h0, 4'h0};
        {channel_select, skip_low_current, above_90pct, below_85pct} = {3'b011, 3'b000, 3'b111, 3'b000};
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        wait (ready);
        for (int i = 0; i < 12; i++) rd(i[3:0], (i == 9) ? 8'h07 : 8'h00);
        for (int i = 0; i < 12; i++) begin
            v = reg_byte_t'($urandom);
            if (i < 10) r[i] = v;
            wr(i[3:0], v);
            rd(i[3:0], (i < 10) ? v : 8'h00);
        end
        check({vout_code, external_feedback_select}, {r[2][5:0], r[1][5:0], r[0][5:0], r[2][7], r[1][7], r[0][7]});
        check({current_limit_code, fsw_code, phase_select}, {r[8][2:0], r[7][2:0], r[6][2:0], r[9][4:0], r[9][6:5]});
        for (int k = 0; k < 3; k++) begin
            n = 25000 / (300 + 100 * codes[k]);
            wr(4'h9, 8'(codes[k]));
            repeat (2) @(posedge sw_clk);
            t0 = $time;
            @(posedge sw_clk);
            check(32'(($time - t0) / 40 inside {[n - 2 : n + 2]}), 32'h1);
        end
        wr(4'h3, 8'h21);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h13);
        sync_run = 1'b1;
        @(negedge clk_sys);
        enable_pin = 1'b1;
        t1 = ticks;
        wait (channel_ramping[0]);
        check(32'(ticks - t1 inside {[2 * DLY - 1 : 2 * DLY + 1]}), 32'h1);
        t1 = ticks;
        wait (channel_running[0]);
        check(32'(ticks - t1 inside {[2 * SS - 1 : 2 * SS + 1]}), 32'h1);
        check(32'(channel_ramping[2] | channel_running[2]), 32'h0);
        wait (power_good_output);
        repeat (60) @(negedge clk_sys);
        check(32'(sync_locked), 32'h1);
        s = 3'($urandom);
        {pulse_skipping_mode, skip_low_current} = {1'b1, s};
        repeat (5) @(negedge clk_sys);
        check({zero_current_detector, pulse_enable}, {3'b011, 3'b011 & ~s});
        below_85pct = 3'b010;
        repeat (6) @(negedge clk_sys);
        check({power_good_output, sync_locked}, 2'b00);
        enable_pin = 1'b0;
        repeat (6) @(negedge clk_sys);
        check({channel_ramping, channel_running}, 6'h00);
        results();
    end
endmodule
